// ==== core/rcs_pkg.sv ====
// Package of constants and carrier types for the reset cause status logic.
package rcs_pkg;
  // ****************************************
  // Register map and field positions
  // ****************************************
  localparam logic [1:0] ADDR_CAUSE = 2'h0;
  localparam logic [1:0] ADDR_STACK = 2'h1;
  localparam logic [1:0] ADDR_PC = 2'h2;
  localparam logic [1:0] ADDR_INTC2 = 2'h3;
  localparam int BIT_PRIO_EN = 7;
  localparam int BIT_SOFT_RST = 4;
  localparam int BIT_TIMEOUT = 3;
  localparam int BIT_PWR_DOWN = 2;
  localparam int BIT_POR = 1;
  localparam int BIT_BROWNOUT = 0;
  localparam int STK_BIT_OVF = 7;
  localparam int STK_BIT_UNF = 6;
  localparam int SP_MSB = 4;
  localparam logic [7:0] CAUSE_IMPL_MASK = 8'h9F;
  localparam logic [7:0] CAUSE_POR_VALUE = 8'h1C;
  // ****************************************
  // Core register reset values, steps, interrupt vectors and masks
  // ****************************************
  localparam logic [20:0] PC_RESET = 21'h000000;
  localparam logic [20:0] PC_STEP = 21'h000002;
  localparam logic [20:0] VEC_HIGH = 21'h000008;
  localparam logic [20:0] VEC_LOW = 21'h000018;
  localparam logic [4:0] SP_RESET = 5'h00;
  localparam logic [4:0] SP_STEP = 5'h01;
  localparam logic [5:0] TBLU_RESET = 6'h00;
  localparam logic [7:0] INTC2_RESET = 8'hF5;
  localparam logic [7:0] INTC2_MASK = 8'hF5;
  localparam logic [20:0] TOS_RESET = 21'h000000;
  // ****************************************
  // Event codes
  // ****************************************
  typedef enum logic [3:0] {
    EV_NONE = 4'h0,
    EV_POR = 4'h1,
    EV_PIN_CLR = 4'h2,
    EV_SOFT = 4'h3,
    EV_STKFULL = 4'h4,
    EV_STKUNDER = 4'h5,
    EV_PIN_CLR_SLEEP = 4'h6,
    EV_WDOG = 4'h7,
    EV_WDOG_WAKE = 4'h8,
    EV_BROWNOUT = 4'h9,
    EV_IRQ_WAKE = 4'hA
  } rcs_event_t;
  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } rcs_bus_t;
  typedef struct packed {
    logic [7:0] cause;
    logic stackOverflow;
    logic stackUnderflow;
    logic [20:0] pc;
    logic [20:0] tos;
    logic [4:0] stackPtr;
    logic [5:0] tblUpper;
    logic [7:0] intc2;
    logic wakeFlag;
    logic [7:0] rdata;
  } rcs_state_t;
endpackage

// ==== core/rcs_reset_cause.sv ====
// Reset cause status register and core register initialisation.
`timescale 1ns/1ps
`default_nettype none
module rcs_reset_cause (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Reset and wake events, one-cycle pulses
  input wire rcs_pkg::rcs_event_t resetEvent,
  input wire logic high_irq_global_enable,
  input wire logic low_irq_global_enable,
  input wire logic highIrqPending,
  // Register port
  input wire logic [1:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  // Core register state
  output logic [7:0] reset_cause_status,
  output logic [20:0] programCounter,
  output logic [20:0] topOfStack,
  output logic [4:0] stack_pointer_reg,
  output logic [5:0] table_pointer_upper,
  output logic [7:0] interrupt_control_second,
  output logic stack_overflow_flag,
  output logic stack_underflow_flag,
  output logic wakeSourceFlag
);
  rcs_pkg::rcs_state_t st;
  rcs_pkg::rcs_state_t next_st;
  rcs_pkg::rcs_bus_t bus;

  assign bus = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    next_st = st;
    next_st.rdata = 8'h00;
    // Software access; a hardware event in the same cycle overrides below.
    if (bus.rd)
    begin
      unique case (bus.addr)
        rcs_pkg::ADDR_CAUSE: next_st.rdata = st.cause & rcs_pkg::CAUSE_IMPL_MASK;
        rcs_pkg::ADDR_STACK: next_st.rdata = {st.stackOverflow, st.stackUnderflow, 1'b0, st.stackPtr};
        rcs_pkg::ADDR_PC: next_st.rdata = st.pc[7:0];
        rcs_pkg::ADDR_INTC2: next_st.rdata = st.intc2 & rcs_pkg::INTC2_MASK;
      endcase
    end
    if (bus.wr)
    begin
      unique case (bus.addr)
        rcs_pkg::ADDR_CAUSE: next_st.cause = bus.wdata & rcs_pkg::CAUSE_IMPL_MASK;
        rcs_pkg::ADDR_STACK:
        begin
          next_st.stackOverflow = bus.wdata[rcs_pkg::STK_BIT_OVF];
          next_st.stackUnderflow = bus.wdata[rcs_pkg::STK_BIT_UNF];
          next_st.stackPtr = bus.wdata[rcs_pkg::SP_MSB:0];
        end
        rcs_pkg::ADDR_PC: next_st.wakeFlag = 1'b0;
        rcs_pkg::ADDR_INTC2: next_st.intc2 = bus.wdata & rcs_pkg::INTC2_MASK;
      endcase
    end
    // Resets that force the core registers to their defaults.
    if (resetEvent inside {rcs_pkg::EV_POR, rcs_pkg::EV_PIN_CLR, rcs_pkg::EV_SOFT, rcs_pkg::EV_STKFULL,
        rcs_pkg::EV_STKUNDER, rcs_pkg::EV_PIN_CLR_SLEEP, rcs_pkg::EV_WDOG, rcs_pkg::EV_BROWNOUT})
    begin
      next_st.pc = rcs_pkg::PC_RESET;
      next_st.tos = rcs_pkg::TOS_RESET;
      next_st.stackPtr = rcs_pkg::SP_RESET;
      next_st.tblUpper = rcs_pkg::TBLU_RESET;
      next_st.intc2 = rcs_pkg::INTC2_RESET;
      next_st.cause[rcs_pkg::BIT_PRIO_EN] = 1'b0;
    end
    unique case (resetEvent)
      rcs_pkg::EV_POR:
      begin
        next_st.cause = rcs_pkg::CAUSE_POR_VALUE;
      end
      rcs_pkg::EV_SOFT:
      begin
        next_st.cause[rcs_pkg::BIT_SOFT_RST] = 1'b0;
      end
      rcs_pkg::EV_STKFULL:
      begin
        next_st.cause[rcs_pkg::BIT_POR] = 1'b1;
        next_st.cause[rcs_pkg::BIT_BROWNOUT] = 1'b1;
        next_st.stackOverflow = 1'b1;
      end
      rcs_pkg::EV_STKUNDER:
      begin
        next_st.cause[rcs_pkg::BIT_POR] = 1'b1;
        next_st.cause[rcs_pkg::BIT_BROWNOUT] = 1'b1;
        next_st.stackUnderflow = 1'b1;
      end
      rcs_pkg::EV_PIN_CLR_SLEEP:
      begin
        next_st.cause[rcs_pkg::BIT_TIMEOUT] = 1'b1;
        next_st.cause[rcs_pkg::BIT_PWR_DOWN] = 1'b0;
      end
      rcs_pkg::EV_WDOG:
      begin
        next_st.cause[rcs_pkg::BIT_SOFT_RST] = 1'b1;
        next_st.cause[rcs_pkg::BIT_TIMEOUT] = 1'b0;
        next_st.cause[rcs_pkg::BIT_PWR_DOWN] = 1'b1;
      end
      rcs_pkg::EV_WDOG_WAKE:
      begin
        next_st.pc = st.pc + rcs_pkg::PC_STEP;
        next_st.cause[rcs_pkg::BIT_TIMEOUT] = 1'b0;
        next_st.cause[rcs_pkg::BIT_PWR_DOWN] = 1'b0;
      end
      rcs_pkg::EV_BROWNOUT:
      begin
        next_st.cause[rcs_pkg::BIT_SOFT_RST] = 1'b1;
        next_st.cause[rcs_pkg::BIT_TIMEOUT] = 1'b1;
        next_st.cause[rcs_pkg::BIT_PWR_DOWN] = 1'b1;
        next_st.cause[rcs_pkg::BIT_POR] = 1'b1;
        next_st.cause[rcs_pkg::BIT_BROWNOUT] = 1'b0;
      end
      rcs_pkg::EV_IRQ_WAKE:
      begin
        next_st.cause[rcs_pkg::BIT_TIMEOUT] = 1'b1;
        next_st.cause[rcs_pkg::BIT_PWR_DOWN] = 1'b0;
        next_st.wakeFlag = 1'b1;
        if (high_irq_global_enable || low_irq_global_enable)
        begin
          next_st.pc = highIrqPending ? rcs_pkg::VEC_HIGH : rcs_pkg::VEC_LOW;
          next_st.tos = st.pc + rcs_pkg::PC_STEP;
          next_st.stackPtr = st.stackPtr + rcs_pkg::SP_STEP;
        end
        else
        begin
          next_st.pc = st.pc + rcs_pkg::PC_STEP;
        end
      end
      default:
      begin
      end
    endcase
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      st <= '0;
      st.cause <= rcs_pkg::CAUSE_POR_VALUE;
      st.intc2 <= rcs_pkg::INTC2_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign regRdata = st.rdata;
  assign reset_cause_status = st.cause;
  assign programCounter = st.pc;
  assign topOfStack = st.tos;
  assign stack_pointer_reg = st.stackPtr;
  assign table_pointer_upper = st.tblUpper;
  assign interrupt_control_second = st.intc2;
  assign stack_overflow_flag = st.stackOverflow;
  assign stack_underflow_flag = st.stackUnderflow;
  assign wakeSourceFlag = st.wakeFlag;
endmodule
`default_nettype wire

// ==== test/rcs_reset_cause_asserts.sv ====
// Concurrent checks on the reset cause status logic.
`timescale 1ns/1ps
`default_nettype none
module rcs_reset_cause_asserts (
  // Clock, reset and events
  input wire logic clk,
  input wire logic sys_rst,
  input wire rcs_pkg::rcs_event_t resetEvent,
  input wire logic high_irq_global_enable,
  input wire logic low_irq_global_enable,
  input wire logic highIrqPending,
  // Core state
  input wire logic [7:0] reset_cause_status,
  input wire logic [20:0] programCounter,
  input wire logic [20:0] topOfStack,
  input wire logic [4:0] stack_pointer_reg,
  input wire logic wakeSourceFlag
);
  // *****
  // Properties
  // *****
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  logic irqOn;
  logic anyReset;
  assign irqOn = resetEvent == rcs_pkg::EV_IRQ_WAKE && (high_irq_global_enable || low_irq_global_enable);
  assign anyReset = !(resetEvent inside {rcs_pkg::EV_NONE, rcs_pkg::EV_WDOG_WAKE, rcs_pkg::EV_IRQ_WAKE});
  a_unused_bits_zero: assert property (reset_cause_status[6:5] == 2'h0)
    else $error("unused cause bits set");
  a_power_on_value: assert property ($fell(sys_rst) |-> reset_cause_status == 8'h1C)
    else $error("wrong power-on cause value");
  a_reset_pc_zero: assert property (anyReset |=> programCounter == 21'h000000)
    else $error("pc not zero after reset");
  a_soft_reset_bits: assert property (resetEvent == rcs_pkg::EV_SOFT |=>
    reset_cause_status == ($past(reset_cause_status) & 8'h0F)) else $error("soft reset bits");
  a_irq_wake_flags: assert property (resetEvent == rcs_pkg::EV_IRQ_WAKE |=>
    reset_cause_status[3:2] == 2'h2 && wakeSourceFlag) else $error("wake flags");
  a_irq_vector_load: assert property (irqOn |=>
    programCounter == ($past(highIrqPending) ? 21'h000008 : 21'h000018)) else $error("vector");
  a_irq_stack_push: assert property (irqOn |=> topOfStack == $past(programCounter) + 21'h000002 &&
    stack_pointer_reg == $past(stack_pointer_reg) + 5'h01) else $error("stack push");
  a_wdog_wake_step: assert property (resetEvent == rcs_pkg::EV_WDOG_WAKE |=>
    programCounter == $past(programCounter) + 21'h000002 && reset_cause_status[3:2] == 2'h0)
    else $error("watchdog wake");
  c_irq_vector: cover property (irqOn);
  c_wdog_wake: cover property (resetEvent == rcs_pkg::EV_WDOG_WAKE);
  c_soft_reset: cover property (resetEvent == rcs_pkg::EV_SOFT);
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
// Self-checking bench for the reset cause status logic.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  rcs_pkg::rcs_event_t resetEvent = rcs_pkg::EV_NONE;
  logic hiEnable = 1'b0, loEnable = 1'b0, highIrqPending = 1'b0, regWr = 1'b0, regRd = 1'b0;
  logic [1:0] regAddr = 2'h0;
  logic [7:0] regWdata = 8'h00;
  logic [7:0] regRdata, cause, intc2, d, eCause, eIntc2;
  logic [20:0] pc, tos, ePc, eTos;
  logic [4:0] sp, eSp;
  logic [5:0] tblu;
  logic ovf, unf, wake, eOvf, eUnf, h, l, p;
  integer seed = 32'hd65c7a45;
  int failures = 0, checkCount = 0, cycles = 0;
  always #20 clk = ~clk;
  rcs_reset_cause DUT (.clk, .sys_rst, .resetEvent, .high_irq_global_enable(hiEnable),
    .low_irq_global_enable(loEnable), .highIrqPending, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
    .reset_cause_status(cause), .programCounter(pc), .topOfStack(tos), .stack_pointer_reg(sp),
    .table_pointer_upper(tblu), .interrupt_control_second(intc2), .stack_overflow_flag(ovf),
    .stack_underflow_flag(unf), .wakeSourceFlag(wake));
  task automatic report_and_stop;
    $display("failures=%0d checks=%0d", failures, checkCount);
    if (failures == 0 && checkCount > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [20:0] g, input logic [20:0] e);
    checkCount++;
    if (g !== e)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk);
    {regAddr, regWdata, regWr} <= {a, v, 1'b1};
    @(posedge clk);
    regWr <= 1'b0;
    #1;
    if (a == rcs_pkg::ADDR_CAUSE) eCause = v & 8'h9F;
    if (a == rcs_pkg::ADDR_INTC2) eIntc2 = v & 8'hF5;
    if (a == rcs_pkg::ADDR_STACK) {eOvf, eUnf, eSp} = {v[7], v[6], v[4:0]};
  endtask
  task automatic rd(input logic [1:0] a);
    @(posedge clk);
    {regAddr, regRd} <= {a, 1'b1};
    @(posedge clk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask
  function automatic logic [7:0] nextCause(input rcs_pkg::rcs_event_t e, input logic [7:0] c);
    case (e)
      rcs_pkg::EV_POR: return 8'h1C;
      rcs_pkg::EV_PIN_CLR: return c & 8'h1F;
      rcs_pkg::EV_SOFT: return c & 8'h0F;
      rcs_pkg::EV_PIN_CLR_SLEEP: return (c & 8'h13) | 8'h08;
      rcs_pkg::EV_WDOG: return (c & 8'h03) | 8'h14;
      rcs_pkg::EV_WDOG_WAKE: return c & 8'h93;
      rcs_pkg::EV_BROWNOUT: return 8'h1E;
      rcs_pkg::EV_IRQ_WAKE: return (c & 8'h93) | 8'h08;
      default: return (c & 8'h1F) | 8'h03;
    endcase
  endfunction
  task automatic fire(input rcs_pkg::rcs_event_t e);
    {h, l, p} = 3'($random(seed));
    eCause = nextCause(e, eCause);
    eOvf = eOvf | (e == rcs_pkg::EV_STKFULL);
    eUnf = eUnf | (e == rcs_pkg::EV_STKUNDER);
    if (!(e inside {rcs_pkg::EV_WDOG_WAKE, rcs_pkg::EV_IRQ_WAKE}))
      {ePc, eTos, eSp, eIntc2} = {47'h0, 8'hF5};
    else if (e == rcs_pkg::EV_IRQ_WAKE && (h || l))
      {eTos, eSp, ePc} = {ePc + 21'h2, eSp + 5'h1, p ? 21'h8 : 21'h18};
    else
      ePc = ePc + 21'h2;
    @(posedge clk);
    resetEvent <= e;
    {hiEnable, loEnable, highIrqPending} <= {h, l, p};
    @(posedge clk);
    resetEvent <= rcs_pkg::EV_NONE;
    #1;
    chk(21'(cause), 21'(eCause));
    chk(pc, ePc);
    chk({tos[15:0], sp}, {eTos[15:0], eSp});
    chk(21'({tblu, intc2, ovf, unf}), 21'({6'h00, eIntc2, eOvf, eUnf}));
    if (e == rcs_pkg::EV_IRQ_WAKE)
    begin
      chk(21'(wake), 21'h1);
      wr(rcs_pkg::ADDR_PC, 8'h00);
      chk(21'(wake), 21'h0);
    end
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles > 3000)
    begin
      failures++;
      report_and_stop();
    end
  end
  initial
  begin
    {ePc, eTos, eSp, eOvf, eUnf, eCause, eIntc2} = {49'h0, 8'h1C, 8'hF5};
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    rd(rcs_pkg::ADDR_CAUSE);
    chk(21'(d), 21'h1C);
    rd(rcs_pkg::ADDR_STACK);
    chk(21'(d), 21'h0);
    wr(rcs_pkg::ADDR_CAUSE, 8'hFF);
    rd(rcs_pkg::ADDR_CAUSE);
    chk(21'(d), 21'h9F);
    wr(rcs_pkg::ADDR_INTC2, 8'hFF);
    rd(rcs_pkg::ADDR_INTC2);
    chk(21'(d), 21'hF5);
    for (int i = 0; i < 60; i++)
    begin
      wr(rcs_pkg::ADDR_CAUSE, 8'($random(seed)));
      wr(rcs_pkg::ADDR_INTC2, 8'($random(seed)));
      wr(rcs_pkg::ADDR_STACK, 8'($random(seed)));
      fire(rcs_pkg::rcs_event_t'(4'(i < 10 ? i + 1 : 1 + $unsigned($random(seed)) % 10)));
      rd(rcs_pkg::ADDR_STACK);
      chk(21'(d), 21'({eOvf, eUnf, 1'b0, eSp}));
    end
    rd(rcs_pkg::ADDR_PC);
    chk(21'(d), 21'(ePc[7:0]));
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd(rcs_pkg::ADDR_CAUSE);
    chk(21'(d), 21'h1C);
    chk(pc, 21'h0);
    chk(21'({tblu, intc2, ovf, unf}), 21'({6'h00, 8'hF5, 2'h0}));
    report_and_stop();
  end
endmodule
bind rcs_reset_cause rcs_reset_cause_asserts chk_inst (.clk, .sys_rst, .resetEvent,
  .high_irq_global_enable, .low_irq_global_enable, .highIrqPending, .reset_cause_status,
  .programCounter, .topOfStack, .stack_pointer_reg, .wakeSourceFlag);
`default_nettype wire
